// File: verilog/shpp_port.sv
// wishbone slave and pin logic of the serial handshake pin port
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module shpp_port (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [shpp_pkg::ADDR_W-1:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [shpp_pkg::DATA_W-1:0] I_WB_DAT,
    output logic [shpp_pkg::DATA_W-1:0] O_WB_DAT,
    output logic O_WB_ACK,
    input wire logic I_REQ_FLOW,
    input wire logic I_REQ_PIN_IN,
    output logic O_REQ_PIN_OUT,
    output logic O_REQ_PIN_OE_N,
    input wire logic I_CLR_PIN_IN,
    output logic O_CLR_PIN_OUT,
    output logic O_CLR_PIN_OE_N,
    output logic O_CLR_FLOW
);
    shpp_pkg::shpp_ctrl_s ctrl_q;
    shpp_pkg::shpp_ctrl_s ctrl_d;
    shpp_pkg::shpp_pins_s pins_q;
    shpp_pkg::shpp_pins_s pins_d;
    logic ack_q;
    logic ack_d;
    logic [shpp_pkg::DATA_W-1:0] rdat_q;
    logic [shpp_pkg::DATA_W-1:0] rdat_d;
    logic req;
    logic wr_lo;

    function automatic logic hit(input logic [shpp_pkg::ADDR_W-1:0] adr,
                                 input logic [shpp_pkg::ADDR_W-1:0] ofs);
        hit = (adr[shpp_pkg::ADDR_W-1:2] == ofs[shpp_pkg::ADDR_W-1:2]);
    endfunction : hit

    // one wait state, no lockout: every request is answered
    assign req = I_WB_CYC && I_WB_STB && !ack_q;
    // only byte lane 0 holds writable bits; upper lanes are reserved
    assign wr_lo = req && I_WB_WE && I_WB_SEL[0];

    always_comb begin
        ctrl_d = ctrl_q;
        ack_d = req;
        rdat_d = '0;
        if (wr_lo && hit(I_WB_ADR, shpp_pkg::OFS_PIN_PORT)) begin
            ctrl_d.req_dir = I_WB_DAT[shpp_pkg::BIT_REQ_DIR];
            ctrl_d.req_data = I_WB_DAT[shpp_pkg::BIT_REQ_DATA];
            ctrl_d.clr_dir = I_WB_DAT[shpp_pkg::BIT_CLR_DIR];
            ctrl_d.clr_data = I_WB_DAT[shpp_pkg::BIT_CLR_DATA];
        end
        if (wr_lo && hit(I_WB_ADR, shpp_pkg::OFS_FLOW_CTRL)) begin
            ctrl_d.flow_en = I_WB_DAT[shpp_pkg::BIT_FLOW_EN];
        end
        if (req && !I_WB_WE && hit(I_WB_ADR, shpp_pkg::OFS_PIN_PORT)) begin
            rdat_d[shpp_pkg::BIT_REQ_DIR] = ctrl_q.req_dir;
            // data bits read the pin, not the stored drive value
            rdat_d[shpp_pkg::BIT_REQ_DATA] = I_REQ_PIN_IN;
            rdat_d[shpp_pkg::BIT_CLR_DIR] = ctrl_q.clr_dir;
            rdat_d[shpp_pkg::BIT_CLR_DATA] = I_CLR_PIN_IN;
        end
        if (req && !I_WB_WE && hit(I_WB_ADR, shpp_pkg::OFS_FLOW_CTRL)) begin
            rdat_d[shpp_pkg::BIT_FLOW_EN] = ctrl_q.flow_en;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_q <= shpp_pkg::CTRL_RESET;
            ack_q <= 1'h0;
            rdat_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // pin side; port direction wins over automatic flow control
    always_comb begin
        pins_d = shpp_pkg::PINS_RESET;
        if (ctrl_q.req_dir) begin
            pins_d.req_out = ctrl_q.req_data;
            pins_d.req_oe_n = 1'h0;
        end else if (ctrl_q.flow_en) begin
            pins_d.req_out = I_REQ_FLOW;
            pins_d.req_oe_n = 1'h0;
        end else begin
            pins_d.req_oe_n = 1'h1;
        end
        if (ctrl_q.clr_dir) begin
            pins_d.clr_out = ctrl_q.clr_data;
            pins_d.clr_oe_n = 1'h0;
        end else begin
            pins_d.clr_oe_n = 1'h1;
        end
        // engine sees clear input stuck low while flow is off
        pins_d.clr_flow = ctrl_q.flow_en ? I_CLR_PIN_IN : 1'h0;
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pins_q <= shpp_pkg::PINS_RESET;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign O_WB_ACK = ack_q;
    assign O_WB_DAT = rdat_q;
    assign O_REQ_PIN_OUT = pins_q.req_out;
    assign O_REQ_PIN_OE_N = pins_q.req_oe_n;
    assign O_CLR_PIN_OUT = pins_q.clr_out;
    assign O_CLR_PIN_OE_N = pins_q.clr_oe_n;
    assign O_CLR_FLOW = pins_q.clr_flow;

    sequence s_port_write;
        I_WB_CYC && I_WB_STB && !ack_q && I_WB_WE && I_WB_SEL[0]
            && hit(I_WB_ADR, shpp_pkg::OFS_PIN_PORT);
    endsequence

    sequence s_port_read;
        I_WB_CYC && I_WB_STB && !ack_q && !I_WB_WE && hit(I_WB_ADR, shpp_pkg::OFS_PIN_PORT);
    endsequence

    chk_reset_value: assert property (@(posedge I_CLK_SYS)
        $rose(I_RST_N) |-> ctrl_q == shpp_pkg::CTRL_RESET)
        else $error("port register not at reset value");
    chk_ack_always: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_WB_CYC && I_WB_STB && !ack_q) |=> ack_q ##1 !ack_q)
        else $error("request not acked in one cycle");
    chk_write_stored: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_port_write |=> ctrl_q.req_dir == $past(I_WB_DAT[shpp_pkg::BIT_REQ_DIR])
            && ctrl_q.clr_data == $past(I_WB_DAT[shpp_pkg::BIT_CLR_DATA]))
        else $error("write not stored");
    chk_reserved_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ack_q |-> O_WB_DAT[31:8] == '0)
        else $error("reserved bits not zero");
    chk_req_drive: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ctrl_q.req_dir |=> !O_REQ_PIN_OE_N && O_REQ_PIN_OUT == $past(ctrl_q.req_data))
        else $error("request pin not driven from port data");
    chk_req_readback: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_port_read |=> O_WB_DAT[shpp_pkg::BIT_REQ_DATA] == $past(I_REQ_PIN_IN))
        else $error("request data does not read pin");
    chk_clr_drive: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ctrl_q.clr_dir |=> !O_CLR_PIN_OE_N && O_CLR_PIN_OUT == $past(ctrl_q.clr_data))
        else $error("clear pin not driven from port data");
    chk_clr_readback: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_port_read |=> O_WB_DAT[shpp_pkg::BIT_CLR_DATA] == $past(I_CLR_PIN_IN)
            && O_WB_DAT[shpp_pkg::BIT_REQ_DIR] == $past(ctrl_q.req_dir))
        else $error("clear data does not read pin");
    chk_clr_fixed: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        !ctrl_q.flow_en |=> !O_CLR_FLOW)
        else $error("clear input not held low");
    chk_pin_release: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!ctrl_q.req_dir && !ctrl_q.flow_en) |=> O_REQ_PIN_OE_N)
        else $error("request pin driven while idle");

    // bus side: one ack per request, nothing else moves the register
    sequence s_flow_write;
        I_WB_CYC && I_WB_STB && !ack_q && I_WB_WE && I_WB_SEL[0]
            && hit(I_WB_ADR, shpp_pkg::OFS_FLOW_CTRL);
    endsequence

    sequence s_flow_read;
        I_WB_CYC && I_WB_STB && !ack_q && !I_WB_WE && hit(I_WB_ADR, shpp_pkg::OFS_FLOW_CTRL);
    endsequence

    chk_ack_unasked: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        !(I_WB_CYC && I_WB_STB) |=> !ack_q)
        else $error("ack without a request");
    chk_ack_single: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ack_q |=> !ack_q)
        else $error("ack longer than one cycle");
    chk_read_idle: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        !ack_q |-> O_WB_DAT == '0)
        else $error("read data outside ack");
    chk_unmapped_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_WB_CYC && I_WB_STB && !ack_q && !I_WB_WE && !hit(I_WB_ADR, shpp_pkg::OFS_PIN_PORT)
            && !hit(I_WB_ADR, shpp_pkg::OFS_FLOW_CTRL)) |=> O_WB_DAT == '0)
        else $error("unmapped read not zero");
    chk_write_rest: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_port_write |=> ctrl_q.req_data == $past(I_WB_DAT[shpp_pkg::BIT_REQ_DATA])
            && ctrl_q.clr_dir == $past(I_WB_DAT[shpp_pkg::BIT_CLR_DIR]))
        else $error("write data bits not stored");
    chk_lane_ignored: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_WB_CYC && I_WB_STB && !ack_q && I_WB_WE && !I_WB_SEL[0]) |=> $stable(ctrl_q))
        else $error("write without lane 0 changed state");
    chk_read_harmless: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (I_WB_CYC && I_WB_STB && !ack_q && !I_WB_WE) |=> $stable(ctrl_q))
        else $error("read changed state");
    chk_flow_stored: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_flow_write |=> ctrl_q.flow_en == $past(I_WB_DAT[shpp_pkg::BIT_FLOW_EN]))
        else $error("flow enable not stored");
    chk_flow_readback: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_flow_read |=> O_WB_DAT[shpp_pkg::BIT_FLOW_EN] == $past(ctrl_q.flow_en))
        else $error("flow enable not read back");

    // pin side: pins trail the register by one cycle
    sequence s_req_port_write;
        I_WB_CYC && I_WB_STB && !ack_q && I_WB_WE && I_WB_SEL[0]
            && hit(I_WB_ADR, shpp_pkg::OFS_PIN_PORT) && I_WB_DAT[shpp_pkg::BIT_REQ_DIR];
    endsequence

    sequence s_clr_port_write;
        I_WB_CYC && I_WB_STB && !ack_q && I_WB_WE && I_WB_SEL[0]
            && hit(I_WB_ADR, shpp_pkg::OFS_PIN_PORT) && I_WB_DAT[shpp_pkg::BIT_CLR_DIR];
    endsequence

    chk_req_write_drive: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_req_port_write |-> ##2 (!O_REQ_PIN_OE_N
            && O_REQ_PIN_OUT == $past(I_WB_DAT[shpp_pkg::BIT_REQ_DATA], 2)))
        else $error("request pin level differs from written data");
    chk_clr_write_drive: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_clr_port_write |-> ##2 (!O_CLR_PIN_OE_N
            && O_CLR_PIN_OUT == $past(I_WB_DAT[shpp_pkg::BIT_CLR_DATA], 2)))
        else $error("clear pin level differs from written data");
    chk_req_flow: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!ctrl_q.req_dir && ctrl_q.flow_en) |=> !O_REQ_PIN_OE_N && O_REQ_PIN_OUT == $past(I_REQ_FLOW))
        else $error("request pin not following flow level");
    chk_clr_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ctrl_q.flow_en |=> O_CLR_FLOW == $past(I_CLR_PIN_IN))
        else $error("clear input not passed to engine");
    chk_clr_release: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        !ctrl_q.clr_dir |=> O_CLR_PIN_OE_N)
        else $error("clear pin driven while idle");
    chk_reset_pins: assert property (@(posedge I_CLK_SYS)
        $rose(I_RST_N) |-> pins_q == shpp_pkg::PINS_RESET && !ack_q && rdat_q == '0)
        else $error("pins or bus not at reset value");
endmodule : shpp_port

// File: verilog/shpp_pkg.sv
// constants and carrier types for the serial handshake pin port
package shpp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // word offsets, byte address on a 32-bit bus
    localparam logic [ADDR_W-1:0] OFS_PIN_PORT = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLOW_CTRL = 8'h04;
    // serial_pin_port_control fields
    localparam int BIT_REQ_DIR = 7;
    localparam int BIT_REQ_DATA = 6;
    localparam int BIT_CLR_DIR = 5;
    localparam int BIT_CLR_DATA = 4;
    localparam logic [REG_W-1:0] PIN_PORT_RESET = 16'h0050;
    // fifo_control_register mirror field
    localparam int BIT_FLOW_EN = 3;
    localparam logic FLOW_EN_RESET = 1'h0;

    typedef struct packed {
        logic req_dir;
        logic req_data;
        logic clr_dir;
        logic clr_data;
        logic flow_en;
    } shpp_ctrl_s;

    typedef struct packed {
        logic req_out;
        logic req_oe_n;
        logic clr_out;
        logic clr_oe_n;
        logic clr_flow;
    } shpp_pins_s;

    localparam shpp_ctrl_s CTRL_RESET = '{
        req_dir: PIN_PORT_RESET[BIT_REQ_DIR],
        req_data: PIN_PORT_RESET[BIT_REQ_DATA],
        clr_dir: PIN_PORT_RESET[BIT_CLR_DIR],
        clr_data: PIN_PORT_RESET[BIT_CLR_DATA],
        flow_en: FLOW_EN_RESET
    };
    localparam shpp_pins_s PINS_RESET = '{
        req_out: 1'h1,
        req_oe_n: 1'h1,
        clr_out: 1'h1,
        clr_oe_n: 1'h1,
        clr_flow: 1'h0
    };
endpackage : shpp_pkg

// File: sim/shpp_peer.sv
// far-side handshake lines: peer drivers plus pull-up
`timescale 1ns/1ps
module shpp_peer (
    input wire logic [1:0] i_dev_out,
    input wire logic [1:0] i_dev_oe_n,
    input wire logic [1:0] i_drive_en,
    input wire logic [1:0] i_drive_val,
    output logic [1:0] o_level
);
    // bit 1 request pin, bit 0 clear pin; pull-up, so a released line reads high
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            if (!i_dev_oe_n[k]) o_level[k] = i_dev_out[k];
            else if (i_drive_en[k]) o_level[k] = i_drive_val[k];
            else o_level[k] = 1'h1;
        end
    end
endmodule : shpp_peer

// File: sim/tb_shpp_port.sv
// self-checking testbench of the serial handshake pin port
`timescale 1ns/1ps
module tb_shpp_port;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] lane = 4'hF;
    logic [31:0] rdat;
    logic ack, req_out, req_oe_n, clr_out, clr_oe_n, clr_flow;
    logic req_flow = 1'h0;
    logic [1:0] lvl;
    logic [1:0] p_en = 2'h0;
    logic [1:0] p_val = 2'h0;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    shpp_port shpp_port_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_REQ_FLOW(req_flow), .I_REQ_PIN_IN(lvl[1]), .O_REQ_PIN_OUT(req_out), .O_REQ_PIN_OE_N(req_oe_n),
        .I_CLR_PIN_IN(lvl[0]), .O_CLR_PIN_OUT(clr_out), .O_CLR_PIN_OE_N(clr_oe_n), .O_CLR_FLOW(clr_flow));
    shpp_peer shpp_peer_i (.i_dev_out({req_out, clr_out}), .i_dev_oe_n({req_oe_n, clr_oe_n}),
        .i_drive_en(p_en), .i_drive_val(p_val), .o_level(lvl));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task give_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit
    // holds the request until ack is sampled, then idles a cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lane;
        do @(posedge clk); while (ack !== 1'h1);
        r = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        sel <= 4'h0;
        @(posedge clk);
    endtask : wb
    task t_reset;
        logic [31:0] r;
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h50);
        wb(1'h0, 8'h04, 32'h0, r); cmp_word(r, 32'h0);
        cmp_bit(req_oe_n & clr_oe_n, 1'h1);
        cmp_bit(clr_flow, 1'h0);
    endtask : t_reset
    task t_drive;
        logic [31:0] r;
        wb(1'h1, 8'h00, 32'h80, r); cmp_bit(lvl[1] | req_oe_n, 1'h0);
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h90);
        wb(1'h1, 8'h00, 32'h60, r); cmp_bit(req_oe_n, 1'h1);
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h60);
        wb(1'h1, 8'h08, 32'hFF, r); cmp_word(r, 32'h0);
        wb(1'h0, 8'h08, 32'h0, r); cmp_word(r, 32'h0);
    endtask : t_drive
    task t_sample;
        logic [31:0] r;
        wb(1'h1, 8'h00, 32'h50, r);
        p_en <= 2'h3;
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h0);
        p_val <= 2'h2;
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h40);
        p_en <= 2'h0;
    endtask : t_sample
    task t_flow;
        logic [31:0] r;
        // port directions already cleared, flow may own the request pin
        wb(1'h1, 8'h04, 32'h8, r);
        wb(1'h0, 8'h04, 32'h0, r); cmp_word(r, 32'h8);
        cmp_bit(clr_flow, 1'h1);
        cmp_bit(req_oe_n | lvl[1], 1'h0);
        req_flow <= 1'h1;
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h50);
        cmp_bit(lvl[1], 1'h1);
        req_flow <= 1'h0;
        wb(1'h1, 8'h04, 32'h0, r); cmp_bit(clr_flow, 1'h0);
    endtask : t_flow
    task t_rst_mid;
        logic [31:0] r;
        // peer pulls both lines low, so only a real drive reads high
        p_val <= 2'h0;
        p_en <= 2'h3;
        wb(1'h1, 8'h00, 32'hF0, r);
        cmp_bit(req_out & clr_out & ~req_oe_n & ~clr_oe_n, 1'h1);
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'hF0);
        lane = 4'hE;
        wb(1'h1, 8'h00, 32'h0, r);
        lane = 4'hF;
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'hF0);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        cmp_bit(req_oe_n & clr_oe_n & ~clr_flow, 1'h1);
        rst_n <= 1'h1;
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h0);
        p_en <= 2'h0;
        wb(1'h0, 8'h00, 32'h0, r); cmp_word(r, 32'h50);
    endtask : t_rst_mid
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_drive();
        t_sample();
        t_flow();
        t_rst_mid();
        give_verdict();
    end
endmodule : tb_shpp_port
